// ### core/nmi_pkg.sv
// constants, types and register map of the nmi source and control block
// Operation
// - deadman timeout sets bit 25, starts countdown
// - watchdog timeout sets bit 24, starts countdown when awake
// - writing one to bit 23 raises nmi
// - general event or written one sets bit 19
// - key 0x4e in key field sets bit 19
// - monitor clock failure sets bit 17 when armed
// - failure with config 0b11 sets both fail bits
// - oscillator fail bit raises nmi, switches oscillator when armed
// - bit 17 raises nmi, never switches clock
// - successful clock switch clears bit 17 only
// - watchdog awake or deadman runs countdown to reset
// - only watchdog and deadman start the countdown
// - unused bits read zero, all reset zero
package nmi_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_NMI_CTL = 8'h00;
  localparam logic [7:0] OFF_INT_CTL = 8'h04;
  localparam logic [7:0] OFF_OSC_CTL = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_CLK_CFG = 8'h14;
  localparam logic [7:0] OFF_UNLOCK = 8'h18;

  // nmi_control_status field positions
  localparam int BIT_DEADMAN = 25;
  localparam int BIT_WATCHDOG = 24;
  localparam int BIT_SW_NMI = 23;
  localparam int BIT_GENERAL = 19;
  localparam int BIT_CLK_FAIL = 17;
  localparam int BIT_WDT_SLEEP = 16;
  localparam int CNT_MSB = 15;
  localparam int CNT_LSB = 0;

  // interrupt_control key field and its trigger value
  localparam int KEY_MSB = 31;
  localparam int KEY_LSB = 24;
  localparam logic [7:0] NMI_KEY_VALUE = 8'h4e;

  // oscillator_control fields
  localparam int OSC_BIT_CLK_FAIL = 3;
  localparam int OSC_BIT_UNLOCKED = 0;

  // clock_monitor_config value that arms the monitor
  localparam logic [1:0] MONITOR_ARMED = 2'h3;

  // unlock keys, arbitrary values
  localparam logic [31:0] UNLOCK_KEY_A = 32'h0000a5a5;
  localparam logic [31:0] UNLOCK_KEY_B = 32'h00005a5a;

  // pin input indexes
  localparam int IN_DEADMAN = 0;
  localparam int IN_WATCHDOG = 1;
  localparam int IN_GENERAL = 2;
  localparam int IN_CLK_FAIL = 3;
  localparam int IN_SWITCH_DONE = 4;
  localparam int IN_SLEEP = 5;
  localparam int NUM_PINS = 6;

  // interrupt status bits
  localparam int IRQ_DEADMAN = 0;
  localparam int IRQ_WATCHDOG = 1;
  localparam int IRQ_SW_NMI = 2;
  localparam int IRQ_GENERAL = 3;
  localparam int IRQ_CLK_FAIL = 4;
  localparam int IRQ_EXPIRE = 5;
  localparam int NUM_IRQ = 6;

  // reset values
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    UNLK_IDLE = 2'b00,
    UNLK_HALF = 2'b01,
    UNLK_OPEN = 2'b10
  } unlock_e;

  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] settled;
    logic deadman_timeout_flag;
    logic watchdog_timeout_flag;
    logic software_nmi_trigger;
    logic general_nmi_flag;
    logic clock_fail_flag;
    logic watchdog_sleep_status;
    logic osc_clock_fail;
    logic [1:0] clock_monitor_config;
    unlock_e unlock;
    logic [NUM_IRQ-1:0] irq_status;
    logic [NUM_IRQ-1:0] irq_mask;
    logic [31:0] rdata;
    logic frc_switch;
    logic reset_req;
  } ctl_s;

  typedef struct packed {
    logic [15:0] count;
    logic running;
    logic expire;
  } cnt_s;

endpackage : nmi_pkg

// ### core/nmi_countdown.sv
// sixteen bit reset countdown started by watchdog and deadman events
`timescale 1ns/1ps
module nmi_countdown (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // control
  input wire logic start,
  input wire logic load,
  input wire logic [15:0] load_value,
  // state
  output logic [15:0] count,
  output logic running,
  output logic expire
);
  import nmi_pkg::*;

  cnt_s state_reg;
  cnt_s state_next;

  // a write reloads the count even mid-run; a start on zero expires next
  always_comb begin
    state_next = state_reg;
    state_next.expire = 1'b0;
    if (state_reg.running) begin
      if (state_reg.count == 16'h0000) begin
        state_next.expire = 1'b1;
        state_next.running = 1'b0;
      end else begin
        state_next.count = state_reg.count - 16'h0001;
      end
    end
    if (load) begin
      state_next.count = load_value;
    end
    if (start) begin
      state_next.running = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= '{count: CNT_RESET, running: 1'b0, expire: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.count;
  assign running = state_reg.running;
  assign expire = state_reg.expire;

endmodule : nmi_countdown

// ### core/nmi_source_control.sv
// nmi source capture, software triggers, clock-fail handling and reset count
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module nmi_source_control (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // event pins from the timers, monitor and clock switch logic
  input wire logic DEADMAN_TIMEOUT,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic GENERAL_NMI_EVENT,
  input wire logic CLOCK_FAIL_DETECT,
  input wire logic CLOCK_SWITCH_DONE,
  input wire logic IN_SLEEP,
  // outputs to the core and the clock and reset units
  output logic NMI_OUT,
  output logic IRQ,
  output logic SWITCH_TO_FRC,
  output logic OSC_CLOCK_FAIL,
  output logic DEVICE_RESET_REQ
);
  import nmi_pkg::*;

  // a pin level counts only once stages two and three agree,
  // so a one-cycle glitch on a pin never reaches a flag
  function automatic logic [NUM_PINS-1:0] settle(
    input logic [NUM_PINS-1:0] s2,
    input logic [NUM_PINS-1:0] s3,
    input logic [NUM_PINS-1:0] prev
  );
    settle = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & prev);
  endfunction : settle

  // zero to one transition of a flag
  function automatic logic rises(input logic nxt, input logic cur);
    rises = nxt & ~cur;
  endfunction : rises

  // sticky status: write-one clears, a set in the same cycle wins
  function automatic logic [NUM_IRQ-1:0] w1c(
    input logic [NUM_IRQ-1:0] cur,
    input logic [NUM_IRQ-1:0] set,
    input logic [NUM_IRQ-1:0] clr
  );
    w1c = (cur & ~clr) | set;
  endfunction : w1c

  // all state of the block except the countdown in one struct, registered in one place
  ctl_s state_reg;
  ctl_s state_next;

  // wiring between the decode, the countdown and the next-state logic
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] pin_rise;
  logic wr_nmi;
  logic wr_int;
  logic wr_osc;
  logic wr_stat;
  logic wr_mask;
  logic wr_cfg;
  logic wr_unlock;
  logic armed;
  logic cnt_start;
  logic cnt_load;
  logic [15:0] cnt_value;
  logic cnt_expire;
  logic [NUM_IRQ-1:0] irq_set;
  logic [31:0] nmi_word;
  logic [31:0] osc_word;

  // gather the pins so they share one synchroniser chain
  always_comb begin
    pins = '0;
    pins[IN_DEADMAN] = DEADMAN_TIMEOUT;
    pins[IN_WATCHDOG] = WATCHDOG_TIMEOUT;
    pins[IN_GENERAL] = GENERAL_NMI_EVENT;
    pins[IN_CLK_FAIL] = CLOCK_FAIL_DETECT;
    pins[IN_SWITCH_DONE] = CLOCK_SWITCH_DONE;
    // the sleep port hides the package index of the same name
    pins[nmi_pkg::IN_SLEEP] = IN_SLEEP;
  end

  // the filtered level changes late, so an edge is seen once per pulse;
  // taken from the registered stages to keep the decode free of loops
  assign pin_rise = settle(state_reg.sync2, state_reg.sync3,
                           state_reg.settled) & ~state_reg.settled;

  // address decode of the write strobe
  assign wr_nmi = REG_WR && (REG_ADDR == OFF_NMI_CTL);
  assign wr_int = REG_WR && (REG_ADDR == OFF_INT_CTL);
  assign wr_osc = REG_WR && (REG_ADDR == OFF_OSC_CTL);
  assign wr_stat = REG_WR && (REG_ADDR == OFF_IRQ_STAT);
  assign wr_mask = REG_WR && (REG_ADDR == OFF_IRQ_MASK);
  assign wr_cfg = REG_WR && (REG_ADDR == OFF_CLK_CFG);
  assign wr_unlock = REG_WR && (REG_ADDR == OFF_UNLOCK);

  // the monitor only acts when its configuration is fully armed
  assign armed = (state_reg.clock_monitor_config == MONITOR_ARMED);

  // readable views of the two mixed registers, unused bits held at zero
  // the count field shows the live count, not the value last written
  always_comb begin
    nmi_word = WORD_RESET;
    nmi_word[BIT_DEADMAN] = state_reg.deadman_timeout_flag;
    nmi_word[BIT_WATCHDOG] = state_reg.watchdog_timeout_flag;
    nmi_word[BIT_SW_NMI] = state_reg.software_nmi_trigger;
    nmi_word[BIT_GENERAL] = state_reg.general_nmi_flag;
    nmi_word[BIT_CLK_FAIL] = state_reg.clock_fail_flag;
    nmi_word[BIT_WDT_SLEEP] = state_reg.watchdog_sleep_status;
    nmi_word[CNT_MSB:CNT_LSB] = cnt_value;
    osc_word = WORD_RESET;
    osc_word[OSC_BIT_CLK_FAIL] = state_reg.osc_clock_fail;
    osc_word[OSC_BIT_UNLOCKED] = (state_reg.unlock == UNLK_OPEN);
  end

  // countdown start and reload; clock-fail, general and software nmis
  // have no path into the start term
  always_comb begin
    cnt_start = 1'b0;
    if (pin_rise[IN_DEADMAN]) begin
      cnt_start = 1'b1;
    end
    if (pin_rise[IN_WATCHDOG]
        && !state_reg.settled[nmi_pkg::IN_SLEEP]) begin
      cnt_start = 1'b1;
    end
    if (wr_nmi && REG_WDATA[BIT_DEADMAN]
        && !state_reg.deadman_timeout_flag) begin
      cnt_start = 1'b1;
    end
    if (wr_nmi && REG_WDATA[BIT_WATCHDOG]
        && !state_reg.watchdog_timeout_flag) begin
      cnt_start = 1'b1;
    end
  end

  // every write of the nmi register reloads the count, even mid-run,
  // so software can stretch or cut a countdown already under way
  assign cnt_load = wr_nmi;

  // the countdown lives in its own module so its reload and expiry
  // rules stay apart from the flag logic
  nmi_countdown u_countdown (
    .SYS_CLK(SYS_CLK),
    .ARST_N(ARST_N),
    .start(cnt_start),
    .load(cnt_load),
    .load_value(REG_WDATA[CNT_MSB:CNT_LSB]),
    .count(cnt_value),
    .running(),
    .expire(cnt_expire)
  );

  // next state: software writes first, then hardware clears, then
  // hardware sets, so an event in a clearing cycle is never lost
  always_comb begin
    state_next = state_reg;
    state_next.frc_switch = 1'b0;
    state_next.reset_req = cnt_expire;

    // three-stage input chain, stage one read only by stage two
    state_next.sync1 = pins;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    state_next.settled = settle(state_reg.sync2, state_reg.sync3,
                                state_reg.settled);

    // plain read/write bits of the nmi register
    if (wr_nmi) begin
      state_next.deadman_timeout_flag = REG_WDATA[BIT_DEADMAN];
      state_next.watchdog_timeout_flag = REG_WDATA[BIT_WATCHDOG];
      state_next.software_nmi_trigger = REG_WDATA[BIT_SW_NMI];
      state_next.general_nmi_flag = REG_WDATA[BIT_GENERAL];
      state_next.clock_fail_flag = REG_WDATA[BIT_CLK_FAIL];
      state_next.watchdog_sleep_status = REG_WDATA[BIT_WDT_SLEEP];
    end

    // key write in the upper byte of interrupt_control
    if (wr_int && (REG_WDATA[KEY_MSB:KEY_LSB] == NMI_KEY_VALUE)) begin
      state_next.general_nmi_flag = 1'b1;
    end

    // two-key unlock opens a single oscillator_control write
    // a wrong second key drops back, so a stray write cannot open it
    if (wr_unlock) begin
      unique case (state_reg.unlock)
        UNLK_IDLE: begin
          if (REG_WDATA == UNLOCK_KEY_A) begin
            state_next.unlock = UNLK_HALF;
          end
        end
        UNLK_HALF: begin
          if (REG_WDATA == UNLOCK_KEY_B) begin
            state_next.unlock = UNLK_OPEN;
          end else begin
            state_next.unlock = UNLK_IDLE;
          end
        end
        UNLK_OPEN: begin
          state_next.unlock = UNLK_OPEN;
        end
        default: begin
          state_next.unlock = UNLK_IDLE;
        end
      endcase
    end

    // a locked write is dropped silently; any write relocks
    if (wr_osc) begin
      if (state_reg.unlock == UNLK_OPEN) begin
        state_next.osc_clock_fail = REG_WDATA[OSC_BIT_CLK_FAIL];
      end
      state_next.unlock = UNLK_IDLE;
    end

    // monitor arming; changing it mid-failure does not undo a switch
    if (wr_cfg) begin
      state_next.clock_monitor_config = REG_WDATA[1:0];
    end

    // interrupt mask is plain storage
    if (wr_mask) begin
      state_next.irq_mask = REG_WDATA[NUM_IRQ-1:0];
    end

    // a completed software switch ends the failure in this register only
    if (pin_rise[IN_SWITCH_DONE] && state_reg.clock_fail_flag) begin
      state_next.clock_fail_flag = 1'b0;
    end

    // hardware sets win over every clear above
    if (pin_rise[IN_DEADMAN]) begin
      state_next.deadman_timeout_flag = 1'b1;
    end
    if (pin_rise[IN_WATCHDOG]) begin
      state_next.watchdog_timeout_flag = 1'b1;
    end
    if (pin_rise[IN_GENERAL]) begin
      state_next.general_nmi_flag = 1'b1;
    end
    if (pin_rise[IN_CLK_FAIL] && armed) begin
      state_next.clock_fail_flag = 1'b1;
      state_next.osc_clock_fail = 1'b1;
    end

    // oscillator fail bit rising, by either party, switches to the rc while armed
    if (rises(state_next.osc_clock_fail, state_reg.osc_clock_fail)
        && armed) begin
      state_next.frc_switch = 1'b1;
    end

    // events that feed the sticky status, taken from the flag edges once
    // every set and clear above has settled in the next state
    irq_set = '0;
    irq_set[IRQ_DEADMAN] = rises(state_next.deadman_timeout_flag,
                                 state_reg.deadman_timeout_flag);
    irq_set[IRQ_WATCHDOG] = rises(state_next.watchdog_timeout_flag,
                                  state_reg.watchdog_timeout_flag);
    irq_set[IRQ_SW_NMI] = rises(state_next.software_nmi_trigger,
                                state_reg.software_nmi_trigger);
    irq_set[IRQ_GENERAL] = rises(state_next.general_nmi_flag,
                                 state_reg.general_nmi_flag);
    irq_set[IRQ_CLK_FAIL] = rises(state_next.clock_fail_flag,
                                  state_reg.clock_fail_flag)
                            | rises(state_next.osc_clock_fail,
                                    state_reg.osc_clock_fail);
    irq_set[IRQ_EXPIRE] = cnt_expire;

    // sticky interrupt status, write-one-to-clear
    state_next.irq_status = w1c(state_reg.irq_status, irq_set,
                                wr_stat ? REG_WDATA[NUM_IRQ-1:0]
                                        : '0);

    // read data appear only in the cycle after the strobe
    state_next.rdata = WORD_RESET;
    if (REG_RD) begin
      unique case (REG_ADDR)
        OFF_NMI_CTL: state_next.rdata = nmi_word;
        OFF_OSC_CTL: state_next.rdata = osc_word;
        OFF_IRQ_STAT: begin
          state_next.rdata[NUM_IRQ-1:0] = state_reg.irq_status;
        end
        OFF_IRQ_MASK: begin
          state_next.rdata[NUM_IRQ-1:0] = state_reg.irq_mask;
        end
        OFF_CLK_CFG: begin
          state_next.rdata[1:0] = state_reg.clock_monitor_config;
        end
        // key and unlock ports are write-only and read back as zero
        OFF_INT_CTL: state_next.rdata = WORD_RESET;
        OFF_UNLOCK: state_next.rdata = WORD_RESET;
        default: state_next.rdata = WORD_RESET;
      endcase
    end
  end

  // every bit clears at power-on
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= '{
        sync1: '0,
        sync2: '0,
        sync3: '0,
        settled: '0,
        deadman_timeout_flag: 1'b0,
        watchdog_timeout_flag: 1'b0,
        software_nmi_trigger: 1'b0,
        general_nmi_flag: 1'b0,
        clock_fail_flag: 1'b0,
        watchdog_sleep_status: 1'b0,
        osc_clock_fail: 1'b0,
        clock_monitor_config: 2'h0,
        unlock: UNLK_IDLE,
        irq_status: '0,
        irq_mask: '0,
        rdata: WORD_RESET,
        frc_switch: 1'b0,
        reset_req: 1'b0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  // nmi stays high while any source flag is held; the handler must
  // clear both fail bits or the line never drops
  assign NMI_OUT = state_reg.deadman_timeout_flag
                 | state_reg.watchdog_timeout_flag
                 | state_reg.software_nmi_trigger
                 | state_reg.general_nmi_flag
                 | state_reg.clock_fail_flag
                 | state_reg.osc_clock_fail;

  // level interrupt and the remaining outputs, all from flip-flops
  assign IRQ = |(state_reg.irq_status & state_reg.irq_mask);
  assign SWITCH_TO_FRC = state_reg.frc_switch;
  assign OSC_CLOCK_FAIL = state_reg.osc_clock_fail;
  assign DEVICE_RESET_REQ = state_reg.reset_req;
  assign REG_RDATA = state_reg.rdata;

endmodule : nmi_source_control

// ### tb/nmi_source_control_properties.sv
// port-level assertion checker for the nmi source and control block
`timescale 1ns/1ps
module nmi_checker (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  // event pins
  input wire logic DEADMAN_TIMEOUT,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic GENERAL_NMI_EVENT,
  input wire logic CLOCK_FAIL_DETECT,
  input wire logic CLOCK_SWITCH_DONE,
  input wire logic IN_SLEEP,
  // outputs
  input wire logic NMI_OUT,
  input wire logic IRQ,
  input wire logic SWITCH_TO_FRC,
  input wire logic OSC_CLOCK_FAIL,
  input wire logic DEVICE_RESET_REQ
);
  import nmi_pkg::*;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);

  // pin steps: low, then seen high; sync stages add three edges
  sequence s_nmi_read;
    REG_RD && REG_ADDR == OFF_NMI_CTL;
  endsequence
  sequence s_dm_rise;
    !DEADMAN_TIMEOUT ##1 DEADMAN_TIMEOUT;
  endsequence

  property p_rdata_idle;
    !REG_RD |=> REG_RDATA == 32'h0;
  endproperty
  property p_unused_zero;
    s_nmi_read |=> (REG_RDATA & 32'hfc74_0000) == 32'h0;
  endproperty
  property p_key_reads_zero;
    REG_RD && REG_ADDR == OFF_INT_CTL |=> REG_RDATA == 32'h0;
  endproperty
  property p_sw_nmi;
    REG_WR && REG_ADDR == OFF_NMI_CTL && REG_WDATA[BIT_SW_NMI]
      |-> ##[1:2] NMI_OUT;
  endproperty
  property p_deadman_nmi;
    s_dm_rise |-> ##[2:5] NMI_OUT;
  endproperty
  property p_watchdog_nmi;
    $rose(WATCHDOG_TIMEOUT) |-> ##[3:6] NMI_OUT;
  endproperty
  property p_general_nmi;
    $rose(GENERAL_NMI_EVENT) |-> ##[3:6] NMI_OUT;
  endproperty
  property p_switch_on_rise;
    SWITCH_TO_FRC |-> $rose(OSC_CLOCK_FAIL) && NMI_OUT;
  endproperty
  property p_switch_pulse;
    SWITCH_TO_FRC |=> !SWITCH_TO_FRC;
  endproperty
  property p_switch_needs_osc;
    SWITCH_TO_FRC |-> OSC_CLOCK_FAIL;
  endproperty
  property p_reset_pulse;
    DEVICE_RESET_REQ |=> !DEVICE_RESET_REQ;
  endproperty

  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read answer");
  a_unused_zero: assert property (p_unused_zero)
    else $error("unimplemented nmi bits read nonzero");
  a_key_reads_zero: assert property (p_key_reads_zero)
    else $error("key register read nonzero");
  a_sw_nmi: assert property (p_sw_nmi)
    else $error("software trigger gave no nmi");
  a_deadman_nmi: assert property (p_deadman_nmi)
    else $error("deadman pin gave no nmi");
  a_watchdog_nmi: assert property (p_watchdog_nmi)
    else $error("watchdog pin gave no nmi");
  a_general_nmi: assert property (p_general_nmi)
    else $error("general pin gave no nmi");
  a_switch_on_rise: assert property (p_switch_on_rise)
    else $error("clock switch without fresh oscillator fail nmi");
  a_switch_pulse: assert property (p_switch_pulse)
    else $error("clock switch request longer than one cycle");
  a_switch_needs_osc: assert property (p_switch_needs_osc)
    else $error("clock switch without oscillator fail bit");
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("reset request longer than one cycle");
endmodule : nmi_checker

bind nmi_source_control nmi_checker i_nmi_checker (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .DEADMAN_TIMEOUT(DEADMAN_TIMEOUT),
  .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
  .GENERAL_NMI_EVENT(GENERAL_NMI_EVENT),
  .CLOCK_FAIL_DETECT(CLOCK_FAIL_DETECT),
  .CLOCK_SWITCH_DONE(CLOCK_SWITCH_DONE), .IN_SLEEP(IN_SLEEP),
  .NMI_OUT(NMI_OUT), .IRQ(IRQ), .SWITCH_TO_FRC(SWITCH_TO_FRC),
  .OSC_CLOCK_FAIL(OSC_CLOCK_FAIL), .DEVICE_RESET_REQ(DEVICE_RESET_REQ)
);

// ### tb/tb.sv
// self-checking bench for the nmi source and control block
`timescale 1ns/1ps
module tb;
  import nmi_pkg::*;

  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [NUM_PINS-1:0] pins = '0;
  logic nmi_out, irq, switch_to_frc, osc_clock_fail, device_reset_req;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0, rst_cnt = 0, sw_cnt = 0, rst_cyc = 0, t0 = 0, d5 = 0;
  int bits[3] = '{BIT_SW_NMI, BIT_GENERAL, BIT_CLK_FAIL};
  logic [31:0] rv;

  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;

  nmi_source_control i_nmi_source_control (
    .SYS_CLK(sys_clk), .ARST_N(arst_n),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .DEADMAN_TIMEOUT(pins[IN_DEADMAN]),
    .WATCHDOG_TIMEOUT(pins[IN_WATCHDOG]),
    .GENERAL_NMI_EVENT(pins[IN_GENERAL]),
    .CLOCK_FAIL_DETECT(pins[IN_CLK_FAIL]),
    .CLOCK_SWITCH_DONE(pins[IN_SWITCH_DONE]),
    .IN_SLEEP(pins[IN_SLEEP]),
    .NMI_OUT(nmi_out), .IRQ(irq), .SWITCH_TO_FRC(switch_to_frc),
    .OSC_CLOCK_FAIL(osc_clock_fail), .DEVICE_RESET_REQ(device_reset_req)
  );

  // count cycles and output pulses; pulses are too short to poll later
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (device_reset_req === 1'b1) begin
      rst_cnt <= rst_cnt + 1;
      rst_cyc <= cyc;
    end
    if (switch_to_frc === 1'b1) begin
      sw_cnt <= sw_cnt + 1;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bchk(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask : bchk

  // bus cycles start on an edge and drop the strobe on the next one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask : rchk

  // pin held four cycles so the synchroniser cannot miss it
  task automatic pulse(input int idx);
    @(posedge sys_clk);
    pins[idx] <= 1'b1;
    t0 = cyc;
    repeat (4) @(posedge sys_clk);
    pins[idx] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse

  task automatic unlock();
    wr(OFF_UNLOCK, UNLOCK_KEY_A);
    wr(OFF_UNLOCK, UNLOCK_KEY_B);
  endtask : unlock

  task automatic summarize();
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // main sequence: reset, then one group of accesses per behaviour
  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    rchk("nmi reg reset", OFF_NMI_CTL, 32'h0);
    rchk("osc reg reset", OFF_OSC_CTL, 32'h0);
    rchk("irq mask reset", OFF_IRQ_MASK, 32'h0);
    bchk("nmi out reset", 1'b0, nmi_out);
    wr(OFF_NMI_CTL, 32'hfc75_1234);
    rchk("nmi reg unused", OFF_NMI_CTL, 32'h0001_1234);
    wr(OFF_NMI_CTL, 32'h0);
    rchk("sleep bit clear", OFF_NMI_CTL, 32'h0);
    foreach (bits[i]) begin
      wr(OFF_NMI_CTL, 32'h1 << bits[i]);
      @(posedge sys_clk);
      #1 bchk("nmi raised", 1'b1, nmi_out);
      repeat (20) @(posedge sys_clk);
      chk("no countdown", 32'h0, rst_cnt);
      chk("no frc switch", 32'h0, sw_cnt);
      wr(OFF_NMI_CTL, 32'h0);
      @(posedge sys_clk);
      #1 bchk("nmi dropped", 1'b0, nmi_out);
    end
    wr(OFF_INT_CTL, 32'h4f00_0000);
    rchk("wrong key", OFF_NMI_CTL, 32'h0);
    wr(OFF_INT_CTL, {NMI_KEY_VALUE, 24'h0});
    rchk("right key", OFF_NMI_CTL, 32'h0008_0000);
    rchk("key reads zero", OFF_INT_CTL, 32'h0);
    // countdown span must follow the loaded value one for one
    wr(OFF_NMI_CTL, 32'h5);
    pulse(IN_DEADMAN);
    repeat (30) @(posedge sys_clk);
    d5 = rst_cyc - t0;
    chk("deadman reset", 32'h1, rst_cnt);
    rchk("deadman flag", OFF_NMI_CTL, 32'h0200_0000);
    wr(OFF_NMI_CTL, 32'h14);
    pulse(IN_WATCHDOG);
    repeat (30) @(posedge sys_clk);
    chk("watchdog reset", 32'h2, rst_cnt);
    chk("count span", 32'd15, (rst_cyc - t0) - d5);
    wr(OFF_NMI_CTL, 32'h3);
    pins[IN_SLEEP] <= 1'b1;
    pulse(IN_WATCHDOG);
    repeat (20) @(posedge sys_clk);
    pins[IN_SLEEP] <= 1'b0;
    chk("asleep no reset", 32'h2, rst_cnt);
    rchk("asleep flag", OFF_NMI_CTL, 32'h0100_0003);
    for (int b = BIT_WATCHDOG; b <= BIT_DEADMAN; b++) begin
      wr(OFF_NMI_CTL, 32'h0);
      wr(OFF_NMI_CTL, (32'h1 << b) | 32'h4);
      repeat (15) @(posedge sys_clk);
    end
    chk("software start", 32'h4, rst_cnt);
    rchk("irq all events", OFF_IRQ_STAT, 32'h3f);
    // clock failure: disarmed, armed, switch done, software clears
    wr(OFF_NMI_CTL, 32'h0);
    pulse(IN_CLK_FAIL);
    rchk("monitor off", OFF_NMI_CTL, 32'h0);
    bchk("osc fail off", 1'b0, osc_clock_fail);
    wr(OFF_CLK_CFG, {30'h0, MONITOR_ARMED});
    pulse(IN_CLK_FAIL);
    rchk("monitor on", OFF_NMI_CTL, 32'h0002_0000);
    bchk("osc fail on", 1'b1, osc_clock_fail);
    chk("frc switch", 32'h1, sw_cnt);
    pulse(IN_SWITCH_DONE);
    rchk("switch clears", OFF_NMI_CTL, 32'h0);
    rchk("osc kept", OFF_OSC_CTL, 32'h8);
    wr(OFF_OSC_CTL, 32'h0);
    rchk("locked osc", OFF_OSC_CTL, 32'h8);
    unlock();
    wr(OFF_OSC_CTL, 32'h0);
    rchk("osc cleared", OFF_OSC_CTL, 32'h0);
    unlock();
    wr(OFF_OSC_CTL, 32'h8);
    rchk("osc sw set", OFF_OSC_CTL, 32'h8);
    bchk("osc nmi", 1'b1, nmi_out);
    chk("sw frc switch", 32'h2, sw_cnt);
    unlock();
    wr(OFF_OSC_CTL, 32'h0);
    // interrupt: clear, raise masked, unmask, clear by writing one
    wr(OFF_IRQ_STAT, 32'h3f);
    rchk("irq cleared", OFF_IRQ_STAT, 32'h0);
    pulse(IN_GENERAL);
    rchk("irq status", OFF_IRQ_STAT, 32'h1 << IRQ_GENERAL);
    bchk("irq masked", 1'b0, irq);
    wr(OFF_IRQ_MASK, 32'h1 << IRQ_GENERAL);
    rchk("irq mask", OFF_IRQ_MASK, 32'h1 << IRQ_GENERAL);
    bchk("irq raised", 1'b1, irq);
    wr(OFF_IRQ_STAT, 32'h1 << IRQ_GENERAL);
    rchk("irq w1c", OFF_IRQ_STAT, 32'h0);
    bchk("irq dropped", 1'b0, irq);
    wr(8'h40, 32'hffff_ffff);
    rchk("unmapped", 8'h40, 32'h0);
    rchk("general flag", OFF_NMI_CTL, 32'h0008_0000);
    summarize();
  end

  // hang guard: the sequence needs well under 2000 cycles
  initial begin
    #50000;
    err_count++;
    summarize();
  end
endmodule : tb
